// ---- rtl/rxpc_checker.sv ----
// module: rx polarity control and pattern checker with axi4-lite regs
//
// Notes on behaviour
// - invert set: negative input treated as data
// - select picks off, 2^7, 2^23, 2^31
// - checker sees raw data before alignment, decoding
// - search for lock, then count mismatches
// - flag high when count reaches threshold
// - threshold is a 32-bit configuration value
// - count clear acts on rising edge only
// - clear edge zeroes count and flag
// - tile, recovery, receive resets zero count
// - width low eight bits, high ten bits; here only ten-bit words are checked and low stops the checker
//
// Added by the designer: the address map and register access over AXI4-Lite.
module rxpc_checker
  import rxpc_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // axi4-lite write channels
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // raw receive words, one per clock
  input  wire logic [WORD_W-1:0] serial_in_pos,
  input  wire logic [WORD_W-1:0] serial_in_neg,
  // asynchronous pins
  input  wire logic              internal_width_select,
  input  wire logic              tile_reset,
  input  wire logic              clock_recovery_reset,
  input  wire logic              receive_reset,
  // results
  output logic                   pattern_error_flag,
  output logic                   irq
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] sync1;                        // first stage only
  logic [3:0] sync2;                        // safe to read
  logic       width_ten;                    // ten-bit datapath
  logic       any_rst;                      // lane reset level

  // two flops per pin; stage one feeds nothing but stage two
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {internal_width_select, tile_reset,
                clock_recovery_reset, receive_reset};
      sync2 <= sync1;
    end
  end

  assign width_ten = sync2[3];
  assign any_rst   = |sync2[2:0];

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  logic [3:0]        ctrl, next_ctrl;       // clear, select, invert
  logic [31:0]       thresh, next_thresh;   // error_threshold_value
  logic [1:0]        int_stat, next_int_stat;
  logic [1:0]        int_mask, next_int_mask;
  logic              aw_held, next_aw_held; // address taken
  logic              w_held, next_w_held;   // data taken
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              next_awready, next_wready, next_bvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              next_arready, next_rvalid;
  logic [31:0]       next_rdata;
  logic              next_irq;
  logic [1:0]        int_set;               // events this cycle
  logic [31:0]       count;                 // error count
  logic              flag;                  // copy of error flag
  rxpc_lock_t        lock;                  // checker lock state
  logic [31:0]       wmerge_ctrl, wmerge_th;

  // byte lane merge for a write with strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // next values of the bus side; one write and one read at a time
  always_comb begin
    next_ctrl     = ctrl;
    next_thresh   = thresh;
    next_int_mask = int_mask;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_awready  = s_axi_awready;
    next_wready   = s_axi_wready;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_arready  = s_axi_arready;
    next_rvalid   = s_axi_rvalid;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    wmerge_ctrl   = merge({28'h0000000, ctrl}, w_data, w_strb);
    wmerge_th     = merge(thresh, w_data, w_strb);
    // set wins over a clear that lands in the same cycle
    next_int_stat = int_stat | int_set;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        ADDR_CTRL:     next_ctrl = wmerge_ctrl[3:0];
        ADDR_THRESH:   next_thresh = wmerge_th;
        ADDR_INT_STAT: begin
          if (w_strb[0]) begin
            next_int_stat = (int_stat & ~w_data[1:0]) | int_set;
          end
        end
        ADDR_INT_MASK: begin
          if (w_strb[0]) begin
            next_int_mask = w_data[1:0];
          end
        end
        ADDR_COUNT, ADDR_STATUS: begin
          next_bresp = RESP_OKAY;           // read only, write dropped
        end
        default:       next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:     next_rdata = {28'h0000000, ctrl};
        ADDR_THRESH:   next_rdata = thresh;
        ADDR_COUNT:    next_rdata = count;
        ADDR_STATUS:   next_rdata = {30'h00000000, lock == RXPC_LOCKED,
                                     flag};
        ADDR_INT_STAT: next_rdata = {30'h00000000, int_stat};
        ADDR_INT_MASK: next_rdata = {30'h00000000, int_mask};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    next_irq = |(next_int_stat & next_int_mask);
  end

  // bus side registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl          <= CTRL_RESET;
      thresh        <= THRESH_RESET;
      int_stat      <= 2'h0;
      int_mask      <= MASK_RESET;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
      irq           <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      thresh        <= next_thresh;
      int_stat      <= next_int_stat;
      int_mask      <= next_int_mask;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      irq           <= next_irq;
    end
  end

  // ****************************************************************
  // pattern checker
  // ****************************************************************
  rxpc_sel_t         sel;                   // pattern_check_select
  logic              rx_invert_polarity;
  logic              clr_level, clr_prev;   // error_count_clear
  logic              clr_edge;
  rxpc_sel_t         sel_prev;
  logic              run;                   // checker may advance
  logic [WORD_W-1:0] rx_word;               // word after polarity
  logic [HIST_W-1:0] hist, next_hist, chk_hist;
  logic [WORD_W-1:0] err_bits;
  logic [3:0]        clean, next_clean;     // clean words in search
  rxpc_lock_t        next_lock;
  logic [31:0]       next_count;
  logic              next_flag;
  logic [32:0]       sum;
  logic [31:0]       nerr;

  assign sel                = rxpc_sel_t'(ctrl[CTRL_SEL_LSB +: 2]);
  assign rx_invert_polarity = ctrl[CTRL_INV_BIT];
  assign clr_level          = ctrl[CTRL_CLR_BIT];
  assign clr_edge           = clr_level && !clr_prev;
  // swapping the legs inverts every bit of the raw word
  assign rx_word = rx_invert_polarity ? serial_in_neg
                                      : serial_in_pos;
  // narrow mode gives no valid result, so the checker stands still
  assign run = (sel != RXPC_SEL_OFF) && width_ten;

  rxpc_word_check #(
    .WW (WORD_W),
    .HW (HIST_W)
  ) u_word_check (
    .pattern_sel (sel),
    .hist        (hist),
    .word        (rx_word),
    .err_bits    (err_bits),
    .next_hist   (chk_hist)
  );

  // next lock, history, count and flag
  always_comb begin
    nerr = 32'h00000000;
    for (int i = 0; i < WORD_W; i++) begin
      nerr = nerr + {31'h00000000, err_bits[i]};
    end
    sum        = {1'b0, count} + {1'b0, nerr};
    next_hist  = run ? chk_hist : hist;
    next_lock  = lock;
    next_clean = clean;
    int_set    = 2'h0;
    // a change of pattern drops lock and starts the search again
    if (!run || sel != sel_prev) begin
      next_lock  = RXPC_SEARCH;
      next_clean = 4'h0;
    end else if (lock == RXPC_SEARCH) begin
      if (err_bits == '0) begin
        next_clean = clean + 4'h1;
        if (clean == LOCK_WORDS - 4'h1) begin
          next_lock             = RXPC_LOCKED;
          int_set[INT_LOCK_BIT] = 1'b1;
        end
      end else begin
        next_clean = 4'h0;
      end
    end
    // count only once locked; stick at the top instead of wrapping
    if (any_rst || clr_edge) begin
      next_count = 32'h00000000;
    end else if (run && lock == RXPC_LOCKED) begin
      next_count = sum[32] ? COUNT_MAX : sum[31:0];
    end else begin
      next_count = count;
    end
    // flag follows the stored count one cycle later
    if (clr_edge || sel == RXPC_SEL_OFF) begin
      next_flag = 1'b0;
    end else begin
      next_flag = (count >= thresh);
    end
    int_set[INT_FLAG_BIT] = next_flag && !flag;
  end

  // checker registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hist               <= '0;
      lock               <= RXPC_SEARCH;
      clean              <= 4'h0;
      count              <= 32'h00000000;
      flag               <= 1'b0;
      pattern_error_flag <= 1'b0;
      clr_prev           <= 1'b0;
      sel_prev           <= RXPC_SEL_OFF;
    end else begin
      hist               <= next_hist;
      lock               <= next_lock;
      clean              <= next_clean;
      count              <= next_count;
      flag               <= next_flag;
      pattern_error_flag <= next_flag;
      clr_prev           <= clr_level;
      sel_prev           <= sel;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_clean_word;
    run && sel == sel_prev && err_bits == '0;
  endsequence

  sequence s_search_start;
    lock == RXPC_SEARCH && clean == 4'h0;
  endsequence

  a_lock_after_clean: assert property (
    s_search_start ##0 s_clean_word [*8] |=> lock == RXPC_LOCKED)
    else $error("no lock after eight clean words");
  a_search_no_count: assert property (
    lock == RXPC_SEARCH && !any_rst && !clr_edge |=> $stable(count))
    else $error("count moved before lock");
  a_flag_at_thresh: assert property (
    sel != RXPC_SEL_OFF && !clr_edge && count >= thresh
      |=> pattern_error_flag)
    else $error("flag missing at threshold");
  a_flag_below: assert property (
    count < thresh |=> !pattern_error_flag)
    else $error("flag set below threshold");
  a_flag_off_mode: assert property (
    sel == RXPC_SEL_OFF |=> !pattern_error_flag)
    else $error("flag set while checking off");
  a_clear_edge: assert property (
    clr_edge |=> count == 32'h00000000 && !pattern_error_flag)
    else $error("clear edge did not clear");
  a_clear_held: assert property (
    clr_prev && clr_level && !any_rst && run && lock == RXPC_LOCKED
      && err_bits != '0 |=> count != 32'h00000000)
    else $error("held clear kept count at zero");
  a_lane_reset: assert property (
    any_rst |=> count == 32'h00000000)
    else $error("lane reset left count");
  a_count_sat: assert property (
    count == COUNT_MAX && !any_rst && !clr_edge |=> count == COUNT_MAX)
    else $error("count wrapped");
  a_polarity_pick: assert property (
    run |=> hist[HIST_W-1 -: WORD_W] == ($past(rx_invert_polarity)
           ? $past(serial_in_neg) : $past(serial_in_pos)))
    else $error("wrong leg taken as data");
  a_narrow_hold: assert property (
    !width_ten |=> $stable(hist) && lock == RXPC_SEARCH)
    else $error("checker ran in narrow mode");

endmodule

// ---- inc/rxpc_pkg.sv ----
// package: constants and types for the rx polarity and pattern checker
package rxpc_pkg;

  // ****************************************************************
  // datapath shape
  // ****************************************************************
  localparam int WORD_W = 10;               // raw word from deserialiser
  localparam int HIST_W = 31;               // longest pattern memory
  localparam int AXI_AW = 8;                // register address width

  // ****************************************************************
  // pattern selection and feedback taps (distance back in the stream)
  // ****************************************************************
  typedef enum logic [1:0] {
    RXPC_SEL_OFF = 2'b00,                   // checking disabled
    RXPC_SEL_P7  = 2'b01,                   // 2^7-1 sequence
    RXPC_SEL_P23 = 2'b10,                   // 2^23-1 sequence
    RXPC_SEL_P31 = 2'b11                    // 2^31-1 sequence
  } rxpc_sel_t;

  localparam int TAP7_A  = 7;
  localparam int TAP7_B  = 6;
  localparam int TAP23_A = 23;
  localparam int TAP23_B = 18;
  localparam int TAP31_A = 31;
  localparam int TAP31_B = 28;

  // ****************************************************************
  // lock search
  // ****************************************************************
  typedef enum logic {
    RXPC_SEARCH = 1'b0,                     // hunting for the sequence
    RXPC_LOCKED = 1'b1                      // predicting and counting
  } rxpc_lock_t;

  localparam logic [3:0] LOCK_WORDS = 4'h8; // clean words before lock

  // ****************************************************************
  // register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [AXI_AW-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_THRESH   = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_COUNT    = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_STATUS   = 8'h0c;
  localparam logic [AXI_AW-1:0] ADDR_INT_STAT = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_INT_MASK = 8'h14;

  localparam int CTRL_INV_BIT = 0;          // rx_invert_polarity
  localparam int CTRL_SEL_LSB = 1;          // pattern_check_select[1:0]
  localparam int CTRL_CLR_BIT = 3;          // error_count_clear
  localparam int STAT_FLAG_BIT = 0;         // pattern_error_flag
  localparam int STAT_LOCK_BIT = 1;         // checker locked
  localparam int INT_FLAG_BIT = 0;          // flag rose
  localparam int INT_LOCK_BIT = 1;          // lock gained

  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [31:0] THRESH_RESET = 32'h00000001;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  localparam logic [31:0] COUNT_MAX    = 32'hffffffff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/rxpc_word_check.sv ----
// module: self-synchronising pattern prediction over one raw word
module rxpc_word_check
  import rxpc_pkg::*;
#(
  parameter int WW = WORD_W,
  parameter int HW = HIST_W
) (
  // pattern choice
  input  wire rxpc_sel_t        pattern_sel,
  // stream
  input  wire logic [HW-1:0]    hist,
  input  wire logic [WW-1:0]    word,
  // results
  output logic      [WW-1:0]    err_bits,
  output logic      [HW-1:0]    next_hist
);

  // ****************************************************************
  // stream view: index 0 oldest, word[0] is the first bit received
  // ****************************************************************
  logic [HW+WW-1:0] ext;                    // history then new word

  assign ext       = {word, hist};
  assign next_hist = ext[HW+WW-1:WW];

  // ****************************************************************
  // per bit: predict from earlier received bits, flag a mismatch
  // ****************************************************************
  // the prediction uses received bits, not a local generator, so the
  // checker reseeds itself from the line and needs no start pattern
  for (genvar i = 0; i < WW; i++) begin : g_bit
    localparam int P = HW + i;
    always_comb begin
      case (pattern_sel)
        RXPC_SEL_P7: begin
          err_bits[i] = ext[P] ^ ext[P-TAP7_A] ^ ext[P-TAP7_B];
        end
        RXPC_SEL_P23: begin
          err_bits[i] = ext[P] ^ ext[P-TAP23_A] ^ ext[P-TAP23_B];
        end
        RXPC_SEL_P31: begin
          err_bits[i] = ext[P] ^ ext[P-TAP31_A] ^ ext[P-TAP31_B];
        end
        default: begin
          err_bits[i] = 1'b0;               // checking off
        end
      endcase
    end
  end

endmodule

// ---- testbench/rxpc_tx_model.sv ----
// partner: remote transmitter sending the selected test pattern
module rxpc_tx_model
  import rxpc_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // control from the bench
  input  wire rxpc_sel_t    pattern,
  input  wire logic         swap,
  input  wire logic         inject,
  // lane legs
  output logic [WORD_W-1:0] serial_in_pos,
  output logic [WORD_W-1:0] serial_in_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [HIST_W-1:0] hist;  // bit k back sits at hist[k-1]

  // next word of the sequence; a flip leaves the history true
  always @(posedge ref_clk) begin
    logic [HIST_W-1:0] t;
    logic [WORD_W-1:0] d;
    t = hist;
    for (int i = 0; i < WORD_W; i++) begin
      case (pattern)
        RXPC_SEL_P7: d[i] = t[TAP7_A-1] ^ t[TAP7_B-1];
        RXPC_SEL_P23: d[i] = t[TAP23_A-1] ^ t[TAP23_B-1];
        default: d[i] = t[TAP31_A-1] ^ t[TAP31_B-1];
      endcase
      t = {t[HIST_W-2:0], d[i]};
    end
    if (inject) d[0] = ~d[0];
    // swap models legs wired the wrong way round
    serial_in_pos <= swap ? ~d : d;
    serial_in_neg <= swap ? d : ~d;
    hist <= reset ? '1 : t;
  end
endmodule

// ---- testbench/testbench.sv ----
// testbench: registers, pattern modes, polarity, clear and resets
module testbench
  import rxpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk, reset, s_axi_awvalid, s_axi_awready;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, irq, swap, inject;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_data, seed;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rd_resp;
  logic [WORD_W-1:0] serial_in_pos, serial_in_neg;
  logic              internal_width_select, tile_reset;
  logic              clock_recovery_reset, receive_reset;
  logic              pattern_error_flag;
  rxpc_sel_t         pattern;
  int                err_total, check_count, n, thr;

  rxpc_checker i_rxpc_checker (.ref_clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_in_pos, .serial_in_neg, .internal_width_select,
    .tile_reset, .clock_recovery_reset, .receive_reset,
    .pattern_error_flag, .irq);
  rxpc_tx_model i_rxpc_tx_model (.ref_clk, .reset, .pattern, .swap,
    .inject, .serial_in_pos, .serial_in_neg);

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status word expected from flag and lock
  function automatic logic [31:0] stat(logic f, logic l);
    return {30'h0, l, f};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // both write channels offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1;
        rd_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rexp(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
    bit got;
    got = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    chk(rd_data, e);
    chk({30'h0, rd_resp}, {30'h0, r});
  endtask
  task automatic setc(input logic inv, input logic [1:0] s, input logic c);
    @(posedge ref_clk);
    pattern <= rxpc_sel_t'(s);
    wr(ADDR_CTRL, {28'h0, c, s, inv});
  endtask
  // one flipped bit, then quiet long enough for all three hits
  task automatic inj();
    @(posedge ref_clk);
    inject <= 1'b1;
    @(posedge ref_clk);
    inject <= 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #300us;
    err_total++;
    complete_run();
  end

  initial begin
    ref_clk = 0;
    reset = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, swap, inject} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {tile_reset, clock_recovery_reset, receive_reset} = '0;
    s_axi_wstrb = 4'hf;
    internal_width_select = 1;
    pattern = RXPC_SEL_OFF;
    seed = 32'hff0c8ba0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rexp(ADDR_CTRL, {28'h0, CTRL_RESET}, RESP_OKAY);
    rexp(ADDR_THRESH, THRESH_RESET, RESP_OKAY);
    rexp(ADDR_INT_MASK, {30'h0, MASK_RESET}, RESP_OKAY);
    rexp(8'h18, 32'h0, RESP_SLVERR);
    $display("test regs done");
    // every pattern: lock, clear, random errors, random threshold
    for (int m = 1; m < 4; m++) begin
      thr = int'(xs() % 12);
      n = int'(xs() % 4) + 1;
      wr(ADDR_THRESH, 32'(thr));
      setc(1'b0, m[1:0], 1'b0);
      wt(20);
      setc(1'b0, m[1:0], 1'b1);
      repeat (n) inj();
      rexp(ADDR_COUNT, 32'(3 * n), RESP_OKAY);
      rexp(ADDR_STATUS, stat(3 * n >= thr, 1'b1), RESP_OKAY);
    end
    $display("test modes done");
    wr(ADDR_THRESH, 32'(3 * n + 3));
    inj();
    rexp(ADDR_COUNT, 32'(3 * n + 3), RESP_OKAY);
    rexp(ADDR_STATUS, stat(1'b1, 1'b1), RESP_OKAY);
    rexp(ADDR_INT_STAT, 32'h3, RESP_OKAY);
    wt(1);
    chk(32'(irq), 32'h0);
    wr(ADDR_INT_MASK, 32'h1);
    wt(2);
    chk(32'(irq), 32'h1);
    wr(ADDR_INT_STAT, 32'h3);
    rexp(ADDR_INT_STAT, 32'h0, RESP_OKAY);
    wt(2);
    chk(32'(irq), 32'h0);
    setc(1'b0, 2'b11, 1'b0);
    setc(1'b0, 2'b11, 1'b1);
    rexp(ADDR_COUNT, 32'h0, RESP_OKAY);
    rexp(ADDR_STATUS, stat(1'b0, 1'b1), RESP_OKAY);
    $display("test clear done");
    wr(ADDR_THRESH, 32'h0);
    setc(1'b0, 2'b00, 1'b0);
    wt(4);
    rexp(ADDR_STATUS, stat(1'b0, 1'b0), RESP_OKAY);
    chk(32'(pattern_error_flag), 32'h0);
    wr(ADDR_COUNT, 32'h5);
    chk({30'h0, rd_resp}, {30'h0, RESP_OKAY});
    rexp(ADDR_COUNT, 32'h0, RESP_OKAY);
    $display("test off done");
    wr(ADDR_THRESH, 32'hffffffff);
    swap <= 1'b1;
    setc(1'b0, 2'b01, 1'b0);
    wt(20);
    rexp(ADDR_STATUS, stat(1'b0, 1'b0), RESP_OKAY);
    setc(1'b1, 2'b01, 1'b0);
    wt(20);
    rexp(ADDR_STATUS, stat(1'b0, 1'b1), RESP_OKAY);
    internal_width_select <= 1'b0;
    wt(6);
    rexp(ADDR_STATUS, stat(1'b0, 1'b0), RESP_OKAY);
    internal_width_select <= 1'b1;
    wt(20);
    $display("test polarity done");
    for (int k = 0; k < 3; k++) begin
      inj();
      rexp(ADDR_COUNT, 32'h3, RESP_OKAY);
      {tile_reset, clock_recovery_reset, receive_reset} <= 3'b100 >> k;
      repeat (4) @(posedge ref_clk);
      {tile_reset, clock_recovery_reset, receive_reset} <= 3'b000;
      wt(4);
      rexp(ADDR_COUNT, 32'h0, RESP_OKAY);
    end
    $display("test resets done");
    complete_run();
  end
endmodule
